// [shared/index_prefix_pkg.sv]
// Types and constants shared by the index prefix address modifier.
package index_prefix_pkg;

   localparam int unsigned ADDR_W    = 24;
   localparam int unsigned OPND_W    = 16;
   localparam logic [1:0]  SCALE_X1  = 2'h0;
   localparam logic [1:0]  SCALE_X2  = 2'h1;
   localparam logic [1:0]  SCALE_X4  = 2'h2;
   localparam logic [OPND_W-1:0] LONG_OPND_MASK = 16'h3FFF;
   localparam logic [OPND_W-1:0] WORD_OPND_MASK = 16'h7FFF;
   localparam logic [OPND_W-1:0] BYTE_OPND_MASK = 16'hFFFF;
   localparam int unsigned BIT_SEL_W = 3;

   typedef enum logic [3:0] {
      byte_index_prefix, byte_dest_index_prefix, byte_src_index_prefix,
      word_index_prefix, word_dest_index_prefix, word_src_index_prefix,
      long_index_prefix, long_dest_index_prefix, long_src_index_prefix,
      bit_offset_prefix
   } prefix_kind_t;

   // Instruction groups as the decoder classifies the follow-on opcode.
   typedef enum logic [4:0] {
      op_add, op_cmp, op_mov, op_sub, op_adc, op_and, op_max, op_min,
      op_mul, op_mulu, op_or, op_sbb, op_tst, op_xor,
      op_unary, op_shift, op_shift_no_carry, op_cond_store, op_div, op_push,
      op_indirect_jump, op_indirect_subroutine_call,
      op_bit_src, op_bit_dst, op_other
   } op_class_t;

   typedef enum logic [1:0] {fmt_general, fmt_quick, fmt_short} op_format_t;
   typedef enum logic [1:0] {size_byte, size_word, size_long, size_addr} op_size_t;

   typedef enum logic [3:0] {
      mode_data_reg, mode_addr_reg, mode_ind_a0, mode_ind_a1,
      mode_dsp8_a, mode_dsp8_base, mode_dsp16_a, mode_dsp16_base,
      mode_dsp24_a, mode_abs16, mode_abs24,
      mode_stack_ptr, mode_dsp8_stack, mode_immediate
   } addr_mode_t;

   typedef struct packed {
      prefix_kind_t      kind;
      logic [OPND_W-1:0] operand;
   } prefix_req_t;

   typedef struct packed {
      op_class_t         op;
      op_format_t        fmt;
      op_size_t          size;
      addr_mode_t        src_mode;
      addr_mode_t        dst_mode;
      logic              src_indirect;
      logic              dst_indirect;
      logic [ADDR_W-1:0] src_addr;
      logic [ADDR_W-1:0] dst_addr;
   } instr_req_t;

   typedef struct packed {
      logic                 legal;
      logic                 src_modified;
      logic                 dst_modified;
      logic [ADDR_W-1:0]    src_addr;
      logic [ADDR_W-1:0]    dst_addr;
      logic                 bit_valid;
      logic [BIT_SEL_W-1:0] bit_sel;
   } addr_result_t;

endpackage : index_prefix_pkg

// [hdl/index_scale_add.sv]
// Unsigned scaled offset adder for one operand address.
`timescale 1ns/1ps
module index_scale_add
   import index_prefix_pkg::*;
#(
   parameter int unsigned AW = ADDR_W,
   parameter int unsigned OW = OPND_W
) (
   input  wire logic [AW-1:0] base,
   input  wire logic [OW-1:0] offset,
   input  wire logic [1:0]    scale,
   output logic      [AW-1:0] sum
);
   logic [AW-1:0] wide_off;

   // Wrapping past the top of the address space is accepted, as in the core adder.
   always_comb begin
      wide_off = AW'(offset);
      if (scale == SCALE_X4) begin
         wide_off = AW'({offset, 2'h0});
      end else if (scale == SCALE_X2) begin
         wide_off = AW'({offset, 1'h0});
      end
      sum = base + wide_off;
   end
endmodule : index_scale_add

// [hdl/index_prefix_address_modifier.sv]
// Index prefix capture, follow-on legality check and operand address modification.
`timescale 1ns/1ps
module index_prefix_address_modifier
   import index_prefix_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic         prefix_valid,
   input  wire prefix_req_t  prefix_req,
   input  wire logic         instr_valid,
   input  wire instr_req_t   instr_req,
   input  wire logic         instr_done,
   output logic              result_valid,
   output addr_result_t      result,
   output logic              prefix_armed,
   output logic              irq_hold
);

   typedef enum logic [1:0] {st_idle, st_armed, st_busy} seq_t;

   typedef struct packed {
      seq_t              seq;
      logic              armed;
      prefix_kind_t      kind;
      logic [OPND_W-1:0] offset;
      logic              res_valid;
      addr_result_t      res;
      logic              hold;
   } state_t;

   state_t            s_q;
   state_t            s_d;
   logic [OPND_W-1:0] eff_off;
   logic [1:0]        scale;
   logic [ADDR_W-1:0] src_sum;
   logic [ADDR_W-1:0] dst_sum;
   logic              ok_op;
   logic              want_src;
   logic              want_dst;
   logic              need_size;
   op_size_t          exp_size;
   logic              ok_src_mode;
   logic              ok_dst_mode;
   logic              ok_fmt;
   logic              ok_stack;

   // Only memory modes that the address generator can index.
   function automatic logic mem_mode_ok(input addr_mode_t m);
      // Registers, stack pointer, stack displacement and immediates are refused.
      mem_mode_ok = (m == mode_ind_a0) || (m == mode_ind_a1) || (m == mode_dsp8_a) ||
                    (m == mode_dsp8_base) || (m == mode_dsp16_a) || (m == mode_dsp16_base) ||
                    (m == mode_dsp24_a) || (m == mode_abs16) || (m == mode_abs24);
   endfunction : mem_mode_ok

   function automatic logic is_group_a(input op_class_t op);
      is_group_a = (op == op_add) || (op == op_cmp) || (op == op_mov) || (op == op_sub) ||
                   (op == op_adc) || (op == op_and) || (op == op_max) || (op == op_min) ||
                   (op == op_mul) || (op == op_mulu) || (op == op_or) || (op == op_sbb) ||
                   (op == op_tst) || (op == op_xor);
   endfunction : is_group_a

   function automatic logic is_long_core(input op_class_t op);
      is_long_core = (op == op_add) || (op == op_cmp) || (op == op_mov) || (op == op_sub);
   endfunction : is_long_core

   function automatic logic is_jump(input op_class_t op);
      is_jump = (op == op_indirect_jump) || (op == op_indirect_subroutine_call);
   endfunction : is_jump

   // Offset trimmed to the legal range and the scaling for the captured prefix.
   always_comb begin
      eff_off = s_q.offset;
      scale   = SCALE_X1;
      case (s_q.kind)
         // Word prefixes double a 15-bit operand.
         word_index_prefix, word_dest_index_prefix, word_src_index_prefix: begin
            eff_off = s_q.offset & WORD_OPND_MASK;
            scale   = SCALE_X2;
         end
         // Long prefixes quadruple a 14-bit operand.
         long_index_prefix, long_dest_index_prefix, long_src_index_prefix: begin
            eff_off = s_q.offset & LONG_OPND_MASK;
            scale   = SCALE_X4;
         end
         // Bit offset becomes a byte step plus a bit position.
         bit_offset_prefix: begin
            eff_off = s_q.offset >> BIT_SEL_W;
         end
         // Byte prefixes add the operand unscaled.
         default: begin
            eff_off = s_q.offset & BYTE_OPND_MASK;
         end
      endcase
   end

   index_scale_add #(.AW(ADDR_W), .OW(OPND_W)) u_src_add (
      .base   (instr_req.src_addr),
      .offset (eff_off),
      .scale  (scale),
      .sum    (src_sum)
   );

   index_scale_add #(.AW(ADDR_W), .OW(OPND_W)) u_dst_add (
      .base   (instr_req.dst_addr),
      .offset (eff_off),
      .scale  (scale),
      .sum    (dst_sum)
   );

   // Which follow-on instructions each prefix accepts and which operand it moves.
   always_comb begin
      ok_op     = 1'b0;
      want_src  = 1'b0;
      want_dst  = 1'b0;
      need_size = 1'b1;
      exp_size  = size_byte;
      case (s_q.kind)
         // Two-operand and source byte/word prefixes take group A only.
         byte_index_prefix, word_index_prefix: begin
            ok_op    = is_group_a(instr_req.op);
            want_src = 1'b1;
            want_dst = 1'b1;
         end
         byte_src_index_prefix, word_src_index_prefix: begin
            ok_op    = is_group_a(instr_req.op);
            want_src = 1'b1;
         end
         // Destination byte/word prefixes take the wider destination set.
         byte_dest_index_prefix, word_dest_index_prefix: begin
            if ((instr_req.op == op_div) || (instr_req.op == op_push)) begin
               ok_op    = 1'b1;
               want_src = 1'b1;
            // Only the word form also indexes the jump table.
            end else if (is_jump(instr_req.op)) begin
               ok_op    = (s_q.kind == word_dest_index_prefix);
               want_src = 1'b1;
            end else begin
               ok_op    = is_group_a(instr_req.op) || (instr_req.op == op_unary) ||
                          (instr_req.op == op_shift) || (instr_req.op == op_cond_store);
               want_dst = 1'b1;
            end
         end
         // Long two-operand prefix indexes both operands.
         long_index_prefix: begin
            ok_op    = is_long_core(instr_req.op);
            want_src = 1'b1;
            want_dst = 1'b1;
         end
         // Long source prefix indexes the source only.
         long_src_index_prefix: begin
            ok_op    = is_long_core(instr_req.op);
            want_src = 1'b1;
         end
         // Long destination prefix: source of multiply, divide and jumps, destination of the rest.
         long_dest_index_prefix: begin
            if ((instr_req.op == op_div) || (instr_req.op == op_mul) ||
                (instr_req.op == op_mulu) || is_jump(instr_req.op)) begin
               ok_op    = 1'b1;
               want_src = 1'b1;
            end else begin
               ok_op    = is_long_core(instr_req.op) || (instr_req.op == op_shift) ||
                          (instr_req.op == op_shift_no_carry);
               want_dst = 1'b1;
            end
         end
         // Bit prefix: source of tests and logic, destination of writes.
         default: begin
            need_size = 1'b0;
            ok_op     = (instr_req.op == op_bit_src) || (instr_req.op == op_bit_dst);
            want_src  = (instr_req.op == op_bit_src);
            want_dst  = (instr_req.op == op_bit_dst);
         end
      endcase
      if ((s_q.kind == word_index_prefix) || (s_q.kind == word_dest_index_prefix) ||
          (s_q.kind == word_src_index_prefix)) begin
         exp_size = size_word;
      end else if ((s_q.kind == long_index_prefix) || (s_q.kind == long_dest_index_prefix) ||
                   (s_q.kind == long_src_index_prefix)) begin
         // Jump table entries are fetched long-word scaled, whatever the size.
         exp_size = is_jump(instr_req.op) ? instr_req.size : size_long;
      end
   end

   // The indirect flag never disqualifies a permitted mode.
   assign ok_src_mode = !want_src || mem_mode_ok(instr_req.src_mode);
   assign ok_dst_mode = !want_dst || mem_mode_ok(instr_req.dst_mode);
   // Add, compare and move must be in general format.
   assign ok_fmt = !is_long_core(instr_req.op) || (instr_req.op == op_sub) ||
                   (instr_req.fmt == fmt_general);
   // Stack pointer refused around an indexed add; no 8-bit stack move.
   assign ok_stack = !(((instr_req.op == op_add) &&
                        ((instr_req.src_mode == mode_stack_ptr) ||
                         (instr_req.dst_mode == mode_stack_ptr))) ||
                       ((instr_req.op == op_mov) &&
                        ((instr_req.src_mode == mode_dsp8_stack) ||
                         (instr_req.dst_mode == mode_dsp8_stack))));

   always_comb begin
      s_d           = s_q;
      s_d.res_valid = 1'b0;
      case (s_q.seq)
         st_idle: begin
            if (prefix_valid) begin
               s_d.seq    = st_armed;
               s_d.armed  = 1'b1;
               s_d.kind   = prefix_req.kind;
               s_d.offset = prefix_req.operand;
               // Interrupts held from the prefix until its partner completes.
               s_d.hold   = 1'b1;
            end
         end
         st_armed: begin
            if (instr_valid) begin
               s_d.seq              = st_busy;
               s_d.armed            = 1'b0;
               s_d.res_valid        = 1'b1;
               // An immediate bit number is ignored; the prefix supplies it.
               s_d.res.legal        = ok_op && ok_src_mode && ok_dst_mode && ok_fmt &&
                                      ok_stack && (!need_size || (instr_req.size == exp_size));
               s_d.res.src_modified = want_src;
               s_d.res.dst_modified = want_dst;
               // Source operand address takes the scaled offset.
               s_d.res.src_addr     = want_src ? src_sum : instr_req.src_addr;
               s_d.res.dst_addr     = want_dst ? dst_sum : instr_req.dst_addr;
               s_d.res.bit_valid    = (s_q.kind == bit_offset_prefix);
               s_d.res.bit_sel      = (s_q.kind == bit_offset_prefix) ?
                                      s_q.offset[BIT_SEL_W-1:0] : '0;
            end
         end
         default: begin
            // Completion is waited for, however many cycles the core needs.
            if (instr_done) begin
               // The offset is forgotten once its one instruction ends.
               s_d.seq    = st_idle;
               s_d.offset = '0;
               s_d.hold   = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign result_valid = s_q.res_valid;
   assign result       = s_q.res;
   assign prefix_armed = s_q.armed;
   assign irq_hold     = s_q.hold;

endmodule : index_prefix_address_modifier

// [bench/index_prefix_props.sv]
// Concurrent checks on the ports of the index prefix address modifier.
`timescale 1ns/1ps
module index_prefix_props
   import index_prefix_pkg::*;
(
   input wire logic         sys_clk,
   input wire logic         rst_n,
   input wire logic         prefix_valid,
   input wire prefix_req_t  prefix_req,
   input wire logic         instr_valid,
   input wire instr_req_t   instr_req,
   input wire logic         instr_done,
   input wire logic         result_valid,
   input wire addr_result_t result,
   input wire logic         prefix_armed,
   input wire logic         irq_hold
);
   logic              took_q;
   prefix_req_t       pr_q;
   instr_req_t        ir_q;
   wire  [ADDR_W-1:0] lofs = {6'h0, pr_q.operand & LONG_OPND_MASK, 2'h0};
   wire  [ADDR_W-1:0] wofs = {7'h0, pr_q.operand & WORD_OPND_MASK, 1'h0};
   wire  [ADDR_W-1:0] bofs = {11'h0, pr_q.operand[15:3]};
   wire               rv_ok = result_valid && result.legal;

   // Keeps the accepted prefix and instruction so results can be judged later.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         took_q <= 1'h0;
         pr_q   <= '0;
         ir_q   <= '0;
      end else begin
         took_q <= instr_valid && prefix_armed;
         if (prefix_valid && !prefix_armed && !irq_hold) pr_q <= prefix_req;
         if (instr_valid && prefix_armed) ir_q <= instr_req;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_arm_on_prefix: assert property (
      prefix_valid && !prefix_armed && !irq_hold |=> prefix_armed && irq_hold)
      else $error("prefix not armed with hold");
   chk_result_timing: assert property (
      instr_valid && prefix_armed |=> result_valid && !prefix_armed)
      else $error("result late or still armed");
   chk_result_cause: assert property (result_valid |-> took_q)
      else $error("result without instruction");
   chk_result_pulse: assert property (result_valid |=> !result_valid)
      else $error("result longer than one cycle");
   chk_hold_covers: assert property (prefix_armed |-> irq_hold)
      else $error("armed without interrupt hold");
   chk_hold_release: assert property (
      instr_done && irq_hold && !prefix_armed |-> ##[1:2] !irq_hold)
      else $error("hold not released after done");
   chk_long_src_scale: assert property (
      rv_ok && pr_q.kind == long_src_index_prefix |->
         result.src_modified && result.src_addr == ir_q.src_addr + lofs)
      else $error("long source offset wrong");
   chk_word_scale: assert property (
      rv_ok && pr_q.kind == word_index_prefix |->
         result.src_addr == ir_q.src_addr + wofs && result.dst_addr == ir_q.dst_addr + wofs)
      else $error("word offset wrong");
   chk_bit_offset: assert property (
      rv_ok && pr_q.kind == bit_offset_prefix && ir_q.op == op_bit_dst |->
         result.dst_addr == ir_q.dst_addr + bofs && result.bit_sel == pr_q.operand[2:0])
      else $error("bit offset wrong");
   chk_long_src_only: assert property (
      result_valid && pr_q.kind == long_src_index_prefix && ir_q.op == op_push |-> !result.legal)
      else $error("push accepted after long source prefix");

   cover property (rv_ok);
   cover property (result_valid && !result.legal);
   cover property (instr_done && irq_hold);
endmodule : index_prefix_props

bind index_prefix_address_modifier index_prefix_props u_props (
   .sys_clk(sys_clk), .rst_n(rst_n), .prefix_valid(prefix_valid), .prefix_req(prefix_req),
   .instr_valid(instr_valid), .instr_req(instr_req), .instr_done(instr_done),
   .result_valid(result_valid), .result(result), .prefix_armed(prefix_armed),
   .irq_hold(irq_hold));

// [bench/exec_stage_model.sv]
// Execution stage stand-in that finishes each follow-on instruction.
`timescale 1ns/1ps
module exec_stage_model (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic result_valid,
   input  wire logic slow,
   output logic      instr_done
);
   logic [2:0] cnt_q;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q      <= 3'h0;
         instr_done <= 1'h0;
      end else begin
         instr_done <= (result_valid && !slow) || cnt_q == 3'h1;
         cnt_q      <= (result_valid && slow) ? 3'h4 : cnt_q - {2'h0, cnt_q != 3'h0};
      end
   end
endmodule : exec_stage_model

// [bench/index_prefix_address_modifier_tb.sv]
// Self-checking bench for the index prefix address modifier.
`timescale 1ns/1ps
module index_prefix_address_modifier_tb
   import index_prefix_pkg::*;
;
   typedef struct packed {
      prefix_kind_t k;
      op_class_t    op;
      op_size_t     sz;
      addr_mode_t   md;
      logic         qk;
      logic [2:0]   fl;
   } tcase_t;
   typedef struct packed {
      logic              lg;
      logic [2:0]        md;
      logic [ADDR_W-1:0] sa;
      logic [ADDR_W-1:0] da;
      logic [2:0]        bs;
   } exp_t;
   localparam tcase_t CASES [22] = '{
      '{byte_index_prefix, op_mov, size_byte, mode_abs16, 1'h0, 3'h7},
      '{byte_src_index_prefix, op_adc, size_byte, mode_abs16, 1'h0, 3'h6},
      '{byte_dest_index_prefix, op_push, size_byte, mode_abs16, 1'h0, 3'h6},
      '{byte_dest_index_prefix, op_unary, size_byte, mode_abs16, 1'h0, 3'h5},
      '{word_index_prefix, op_xor, size_word, mode_abs16, 1'h0, 3'h7},
      '{word_src_index_prefix, op_mulu, size_word, mode_abs16, 1'h0, 3'h6},
      '{word_dest_index_prefix, op_indirect_jump, size_word, mode_abs16, 1'h0, 3'h6},
      '{word_dest_index_prefix, op_shift, size_word, mode_abs16, 1'h0, 3'h5},
      '{long_index_prefix, op_sub, size_long, mode_abs16, 1'h0, 3'h7},
      '{long_src_index_prefix, op_cmp, size_long, mode_abs16, 1'h0, 3'h6},
      '{long_dest_index_prefix, op_shift_no_carry, size_long, mode_abs16, 1'h0, 3'h5},
      '{long_dest_index_prefix, op_indirect_subroutine_call, size_addr, mode_abs16, 1'h0, 3'h6},
      '{long_dest_index_prefix, op_div, size_long, mode_abs16, 1'h0, 3'h6},
      '{bit_offset_prefix, op_bit_src, size_byte, mode_abs16, 1'h0, 3'h6},
      '{bit_offset_prefix, op_bit_dst, size_byte, mode_abs16, 1'h0, 3'h5},
      '{long_src_index_prefix, op_push, size_long, mode_abs16, 1'h0, 3'h0},
      '{word_index_prefix, op_mov, size_word, mode_abs16, 1'h1, 3'h0},
      '{byte_index_prefix, op_add, size_byte, mode_stack_ptr, 1'h0, 3'h0},
      '{long_index_prefix, op_mov, size_long, mode_dsp8_stack, 1'h0, 3'h0},
      // wrong size, register or immediate operand refused
      '{long_src_index_prefix, op_mov, size_word, mode_abs16, 1'h0, 3'h0},
      '{long_dest_index_prefix, op_add, size_long, mode_data_reg, 1'h0, 3'h0},
      '{byte_src_index_prefix, op_and, size_byte, mode_immediate, 1'h0, 3'h0}};

   logic         sys_clk;
   logic         rst_n        = 1'h0;
   logic         prefix_valid = 1'h0;
   prefix_req_t  prefix_req   = '0;
   logic         instr_valid  = 1'h0;
   instr_req_t   instr_req    = '0;
   logic         instr_done;
   logic         slow         = 1'h0;
   logic         result_valid;
   addr_result_t result;
   logic         prefix_armed;
   logic         irq_hold;
   int           n_errors     = 0;
   int           cmp_count    = 0;
   int           cycles       = 0;
   exp_t         q [$];
   exp_t         me;

   index_prefix_address_modifier dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .prefix_valid(prefix_valid), .prefix_req(prefix_req), .instr_valid(instr_valid),
      .instr_req(instr_req), .instr_done(instr_done), .result_valid(result_valid),
      .result(result), .prefix_armed(prefix_armed), .irq_hold(irq_hold));
   exec_stage_model far_end (.sys_clk(sys_clk), .rst_n(rst_n), .result_valid(result_valid),
      .slow(slow), .instr_done(instr_done));

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Operands stay in the range software may give each prefix.
   function automatic logic [15:0] msk(input prefix_kind_t k);
      if (k inside {long_index_prefix, long_dest_index_prefix, long_src_index_prefix})
         return LONG_OPND_MASK;
      if (k inside {word_index_prefix, word_dest_index_prefix, word_src_index_prefix})
         return WORD_OPND_MASK;
      return BYTE_OPND_MASK;
   endfunction : msk

   function automatic logic [ADDR_W-1:0] off(input prefix_kind_t k, input logic [15:0] o);
      if (k == bit_offset_prefix) return {11'h0, o[15:3]};
      if (msk(k) == LONG_OPND_MASK) return {6'h0, o, 2'h0};
      if (msk(k) == WORD_OPND_MASK) return {7'h0, o, 1'h0};
      return {8'h0, o};
   endfunction : off

   task automatic run(input tcase_t c, input int i, input logic dup);
      instr_req_t  ir;
      exp_t        e;
      logic [15:0] opn;
      int          w;
      opn = (i % 4 == 0) ? msk(c.k) : 16'($urandom) & msk(c.k);
      ir.op = c.op;
      ir.fmt = c.qk ? fmt_quick : fmt_general;
      ir.size = c.sz;
      // every permitted mode, direct or indirect
      ir.src_mode = c.fl[2] ? addr_mode_t'(4'(2 + i % 9)) : c.md;
      ir.dst_mode = ir.src_mode;
      ir.src_indirect = 1'($urandom);
      ir.dst_indirect = 1'($urandom);
      ir.src_addr = 24'($urandom);
      ir.dst_addr = 24'($urandom);
      e = '{c.fl[2], {c.fl[1:0], c.k == bit_offset_prefix}, ir.src_addr, ir.dst_addr, opn[2:0]};
      if (c.fl[1]) e.sa = ir.src_addr + off(c.k, opn);
      if (c.fl[0]) e.da = ir.dst_addr + off(c.k, opn);
      @(posedge sys_clk);
      prefix_valid <= 1'h1;
      prefix_req <= '{c.k, opn};
      instr_valid <= dup;
      @(posedge sys_clk);
      prefix_valid <= dup;
      prefix_req <= '{c.k, ~opn & msk(c.k)};
      instr_valid <= 1'h1;
      instr_req <= ir;
      slow <= 1'($urandom);
      q.push_back(e);
      @(posedge sys_clk);
      prefix_valid <= 1'h0;
      instr_valid <= 1'h0;
      w = 0;
      do begin
         @(posedge sys_clk);
         w++;
      end while (irq_hold !== 1'h0 && w < 20);
      if (w >= 20) check(32'(irq_hold), 32'h0);
   endtask : run

   initial begin
      sys_clk = 1'h0;
      forever #20 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         stop_test;
      end
   end

   // Outputs are read at the falling edge, where they have settled.
   always @(negedge sys_clk) begin
      if (result_valid === 1'h1) begin
         if (q.size() == 0) check(32'h1, 32'h0);
         else begin
            me = q.pop_front();
            check(32'(result.legal), 32'(me.lg));
            if (me.lg) begin
               check(32'({result.src_modified, result.dst_modified, result.bit_valid}),
                     32'(me.md));
               check(32'(result.src_addr), 32'(me.sa));
               check(32'(result.dst_addr), 32'(me.da));
               if (me.md[0]) check(32'(result.bit_sel), 32'(me.bs));
            end
         end
      end
   end

   initial begin
      void'($urandom(32'h7d10b1bd));
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'h1;
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 22; i++) begin
            run(CASES[i], i + r, (i + r) % 3 == 0);
         end
      end
      repeat (4) @(posedge sys_clk);
      check(32'(q.size()), 32'h0);
      stop_test;
   end
endmodule : index_prefix_address_modifier_tb
